// ### src/irq_prio_pkg.sv
// Register map, field positions and carrier types of the interrupt priority block
package irq_prio_pkg;

	// Source count and index width
	localparam int unsigned NUM_SRC      = 10;
	localparam int unsigned NUM_CORE_SRC = 7;
	localparam int unsigned SRC_IDX_W    = 4;

	// Special-function addresses
	localparam logic [7:0] CORE_PRIO_ADDR = 8'hb8;
	localparam logic [7:0] EXT_EN_ADDR    = 8'he6;
	localparam logic [7:0] EXT_PRIO_ADDR  = 8'hf6;

	// Reset values and the read value of unmapped addresses
	localparam logic [7:0] CORE_PRIO_RESET = 8'h80;
	localparam logic [7:0] EXT_EN_RESET    = 8'h00;
	localparam logic [7:0] EXT_PRIO_RESET  = 8'h00;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// Core priority register fields
	localparam int unsigned EXT_EDGE0_BIT       = 0;
	localparam int unsigned TIMER2_BIT          = 1;
	localparam int unsigned TEMP_DEMOD_BIT      = 2;
	localparam int unsigned TICK_BIT            = 3;
	localparam int unsigned SERIALIZER_BIT      = 4;
	localparam int unsigned TIMER3_BIT          = 5;
	localparam int unsigned EXT_EDGE1_BIT       = 6;
	localparam int unsigned CORE_PRIO_FIXED_BIT = 7;

	// Extended enable and priority register fields
	localparam int unsigned FREQ_CNT_BIT  = 2;
	localparam int unsigned SOFT_SRC0_BIT = 3;
	localparam int unsigned SOFT_SRC1_BIT = 4;
	localparam int unsigned EXT_FIELD_LSB = 2;
	localparam int unsigned EXT_FIELD_W   = 3;

	// Source indices, in fixed resolution order
	localparam int unsigned SRC_EXT_EDGE0  = 0;
	localparam int unsigned SRC_TIMER2     = 1;
	localparam int unsigned SRC_TEMP_DEMOD = 2;
	localparam int unsigned SRC_TICK       = 3;
	localparam int unsigned SRC_SERIALIZER = 4;
	localparam int unsigned SRC_TIMER3     = 5;
	localparam int unsigned SRC_EXT_EDGE1  = 6;
	localparam int unsigned SRC_FREQ_CNT   = 7;
	localparam int unsigned SRC_SOFT0      = 8;
	localparam int unsigned SRC_SOFT1      = 9;

	// Vector layout: two reserved slots sit between the core and extended sources
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;
	localparam logic [15:0] ORDER_GAP   = 16'h0002;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wdata;
		logic       wr;
		logic       rd;
	} sfr_bit_req_t;

	typedef struct packed {
		logic                 valid;
		logic                 high;
		logic [SRC_IDX_W-1:0] src;
		logic [15:0]          vector;
	} irq_req_t;

	typedef struct packed {
		logic hi_active;
		logic lo_active;
	} in_service_t;

endpackage

// ### src/irq_arbiter.sv
// Fixed-order two-level arbiter over the enabled pending sources
`timescale 1ns/10ps
module irq_arbiter #(
	parameter int unsigned NUM_SRC = irq_prio_pkg::NUM_SRC
)
(
	input  wire logic [NUM_SRC-1:0]                 req_i,
	input  wire logic [NUM_SRC-1:0]                 high_i,
	input  wire irq_prio_pkg::in_service_t          busy_i,
	output logic                                    grant_o,
	output logic                                    grant_high_o,
	output logic [irq_prio_pkg::SRC_IDX_W-1:0]      grant_src_o
);

	logic [NUM_SRC-1:0] hi_req;
	logic [NUM_SRC-1:0] lo_req;
	logic               hi_ok;
	logic               lo_ok;

	// Lowest index wins; scanning downward lets the last hit be the lowest
	function automatic logic [irq_prio_pkg::SRC_IDX_W-1:0] first_set(
		input logic [NUM_SRC-1:0] v
	);
		logic [irq_prio_pkg::SRC_IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = irq_prio_pkg::SRC_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_split
		assign hi_req[i] = req_i[i] & high_i[i];
		assign lo_req[i] = req_i[i] & ~high_i[i];
	end

	// High may preempt a low handler; low waits for both levels idle
	assign hi_ok        = (|hi_req) & ~busy_i.hi_active;
	assign lo_ok        = (|lo_req) & ~busy_i.hi_active & ~busy_i.lo_active;
	assign grant_o      = hi_ok | lo_ok;
	assign grant_high_o = hi_ok;
	assign grant_src_o  = hi_ok ? first_set(hi_req) : first_set(lo_req);

endmodule

// ### src/in_service_tracker.sv
// Tracks which priority levels have a handler in progress
`timescale 1ns/10ps
module in_service_tracker (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_b_i,
	input  wire logic                      ack_i,
	input  wire logic                      ack_high_i,
	input  wire logic                      reti_i,
	output irq_prio_pkg::in_service_t      busy_o
);

	irq_prio_pkg::in_service_t state_q;
	irq_prio_pkg::in_service_t state_d;

	always_comb
	begin
		state_d = state_q;
		// A return closes the innermost handler, which is the high one if any
		if (reti_i)
		begin
			if (state_q.hi_active)
			begin
				state_d.hi_active = 1'b0;
			end
			else
			begin
				state_d.lo_active = 1'b0;
			end
		end
		if (ack_i)
		begin
			if (ack_high_i)
			begin
				state_d.hi_active = 1'b1;
			end
			else
			begin
				state_d.lo_active = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign busy_o = state_q;

endmodule

// ### src/irq_prio_ctrl.sv
// Interrupt priority and extended enable registers with request resolution
`timescale 1ns/10ps
module irq_prio_ctrl #(
	parameter int unsigned NUM_SRC      = irq_prio_pkg::NUM_SRC,
	parameter int unsigned NUM_CORE_SRC = irq_prio_pkg::NUM_CORE_SRC
)
(
	input  wire logic                         mclk_i,
	input  wire logic                         rst_b_i,
	input  wire irq_prio_pkg::sfr_req_t       sfr_i,
	input  wire irq_prio_pkg::sfr_bit_req_t   sfr_bit_i,
	input  wire logic                         global_irq_enable_i,
	input  wire logic [NUM_CORE_SRC-1:0]      core_irq_enable_i,
	input  wire logic [NUM_CORE_SRC-1:0]      core_pending_i,
	input  wire logic                         freq_counter_pending_i,
	input  wire logic                         soft_flag_wr_i,
	input  wire logic [1:0]                   soft_flag_wdata_i,
	input  wire logic                         irq_ack_i,
	input  wire logic                         irq_reti_i,
	output logic [7:0]                        sfr_rdata_o,
	output logic                              sfr_bit_rdata_o,
	output irq_prio_pkg::irq_req_t            irq_o,
	output logic [7:0]                        core_interrupt_priority_o,
	output logic [7:0]                        extended_interrupt_enable_o,
	output logic [7:0]                        extended_interrupt_priority_o,
	output logic [1:0]                        soft_src_pending_o,
	output irq_prio_pkg::in_service_t         in_service_o
);

	typedef struct packed {
		logic [NUM_CORE_SRC-1:0]              core_prio;
		logic [irq_prio_pkg::EXT_FIELD_W-1:0] ext_en;
		logic [irq_prio_pkg::EXT_FIELD_W-1:0] ext_prio;
		logic [1:0]                           soft_pend;
		logic [7:0]                           rdata;
		logic                                 bit_rdata;
		irq_prio_pkg::irq_req_t               irq;
	} ctrl_state_t;

	ctrl_state_t state_q;
	ctrl_state_t state_d;

	logic [7:0]                           core_prio_view;
	logic [7:0]                           ext_en_view;
	logic [7:0]                           ext_prio_view;
	logic [NUM_SRC-1:0]                   src_pending;
	logic [NUM_SRC-1:0]                   src_enable;
	logic [NUM_SRC-1:0]                   src_high;
	logic [NUM_SRC-1:0]                   src_req;
	logic                                 grant;
	logic                                 grant_high;
	logic [irq_prio_pkg::SRC_IDX_W-1:0]   grant_src;
	irq_prio_pkg::in_service_t            busy;
	logic                                 bit_hits_core;
	logic [2:0]                           bit_idx;

	// Vector address of a source; the extended sources skip the reserved slots
	function automatic logic [15:0] vector_of(
		input logic [irq_prio_pkg::SRC_IDX_W-1:0] src
	);
		logic [15:0] order;
		order = {12'h000, src};
		if (src >= irq_prio_pkg::SRC_IDX_W'(NUM_CORE_SRC))
		begin
			order = order + irq_prio_pkg::ORDER_GAP;
		end
		return irq_prio_pkg::VECTOR_BASE + 16'(order * irq_prio_pkg::VECTOR_STEP);
	endfunction

	// Byte image of a register as software sees it
	function automatic logic [7:0] ext_view(
		input logic [irq_prio_pkg::EXT_FIELD_W-1:0] field
	);
		logic [7:0] v;
		v = 8'h00;
		v[irq_prio_pkg::EXT_FIELD_LSB +: irq_prio_pkg::EXT_FIELD_W] = field;
		return v;
	endfunction

	// Bit 7 is not stored; it is forced to one on every read
	assign core_prio_view = {1'b1, state_q.core_prio};
	assign ext_en_view    = ext_view(state_q.ext_en);
	assign ext_prio_view  = ext_view(state_q.ext_prio);

	// Source vectors in fixed resolution order
	always_comb
	begin
		src_pending = '0;
		src_enable  = '0;
		src_high    = '0;
		src_pending[NUM_CORE_SRC-1:0] = core_pending_i;
		src_enable[NUM_CORE_SRC-1:0]  = core_irq_enable_i;
		src_high[irq_prio_pkg::SRC_EXT_EDGE0]  =
			core_prio_view[irq_prio_pkg::EXT_EDGE0_BIT];
		src_high[irq_prio_pkg::SRC_TIMER2]     =
			core_prio_view[irq_prio_pkg::TIMER2_BIT];
		src_high[irq_prio_pkg::SRC_TEMP_DEMOD] =
			core_prio_view[irq_prio_pkg::TEMP_DEMOD_BIT];
		src_high[irq_prio_pkg::SRC_TICK]       =
			core_prio_view[irq_prio_pkg::TICK_BIT];
		src_high[irq_prio_pkg::SRC_SERIALIZER] =
			core_prio_view[irq_prio_pkg::SERIALIZER_BIT];
		src_high[irq_prio_pkg::SRC_TIMER3]     =
			core_prio_view[irq_prio_pkg::TIMER3_BIT];
		src_high[irq_prio_pkg::SRC_EXT_EDGE1]  =
			core_prio_view[irq_prio_pkg::EXT_EDGE1_BIT];

		src_pending[irq_prio_pkg::SRC_FREQ_CNT] = freq_counter_pending_i;
		src_pending[irq_prio_pkg::SRC_SOFT0]    = state_q.soft_pend[0];
		src_pending[irq_prio_pkg::SRC_SOFT1]    = state_q.soft_pend[1];
		src_enable[irq_prio_pkg::SRC_FREQ_CNT]  =
			ext_en_view[irq_prio_pkg::FREQ_CNT_BIT];
		src_enable[irq_prio_pkg::SRC_SOFT0]     =
			ext_en_view[irq_prio_pkg::SOFT_SRC0_BIT];
		src_enable[irq_prio_pkg::SRC_SOFT1]     =
			ext_en_view[irq_prio_pkg::SOFT_SRC1_BIT];
		src_high[irq_prio_pkg::SRC_FREQ_CNT]    =
			ext_prio_view[irq_prio_pkg::FREQ_CNT_BIT];
		src_high[irq_prio_pkg::SRC_SOFT0]       =
			ext_prio_view[irq_prio_pkg::SOFT_SRC0_BIT];
		src_high[irq_prio_pkg::SRC_SOFT1]       =
			ext_prio_view[irq_prio_pkg::SOFT_SRC1_BIT];
	end

	// The global enable overrides every individual mask
	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_gate
		assign src_req[i] = src_pending[i] & src_enable[i] & global_irq_enable_i;
	end

	irq_arbiter #(
		.NUM_SRC (NUM_SRC)
	) u_arbiter (
		.req_i        (src_req),
		.high_i       (src_high),
		.busy_i       (busy),
		.grant_o      (grant),
		.grant_high_o (grant_high),
		.grant_src_o  (grant_src)
	);

	// The acknowledged request is the registered one the core saw
	in_service_tracker u_tracker (
		.mclk_i     (mclk_i),
		.rst_b_i    (rst_b_i),
		.ack_i      (irq_ack_i & state_q.irq.valid),
		.ack_high_i (state_q.irq.high),
		.reti_i     (irq_reti_i),
		.busy_o     (busy)
	);

	assign bit_hits_core = (sfr_bit_i.addr[7:3] == irq_prio_pkg::CORE_PRIO_ADDR[7:3]);
	assign bit_idx       = sfr_bit_i.addr[2:0];

	always_comb
	begin
		state_d = state_q;

		// Byte writes; a byte write and a bit write never share a cycle on the core bus
		if (sfr_i.wr)
		begin
			if (sfr_i.addr == irq_prio_pkg::CORE_PRIO_ADDR)
			begin
				state_d.core_prio = sfr_i.wdata[NUM_CORE_SRC-1:0];
			end
			else if (sfr_i.addr == irq_prio_pkg::EXT_EN_ADDR)
			begin
				// Bits 1:0 are not stored; software leaves them zero
				state_d.ext_en = sfr_i.wdata[irq_prio_pkg::EXT_FIELD_LSB +:
					irq_prio_pkg::EXT_FIELD_W];
			end
			else if (sfr_i.addr == irq_prio_pkg::EXT_PRIO_ADDR)
			begin
				state_d.ext_prio = sfr_i.wdata[irq_prio_pkg::EXT_FIELD_LSB +:
					irq_prio_pkg::EXT_FIELD_W];
			end
		end
		else if (sfr_bit_i.wr && bit_hits_core)
		begin
			// Single-bit write; the fixed top bit swallows it
			if (bit_idx != 3'(irq_prio_pkg::CORE_PRIO_FIXED_BIT))
			begin
				state_d.core_prio[bit_idx] = sfr_bit_i.wdata;
			end
		end

		// Only a software write sets these flags; a software write or reset clears them
		if (soft_flag_wr_i)
		begin
			state_d.soft_pend = soft_flag_wdata_i;
		end

		// Registered byte read; unmapped addresses return zero
		if (sfr_i.rd)
		begin
			if (sfr_i.addr == irq_prio_pkg::CORE_PRIO_ADDR)
			begin
				state_d.rdata = core_prio_view;
			end
			else if (sfr_i.addr == irq_prio_pkg::EXT_EN_ADDR)
			begin
				state_d.rdata = ext_en_view;
			end
			else if (sfr_i.addr == irq_prio_pkg::EXT_PRIO_ADDR)
			begin
				state_d.rdata = ext_prio_view;
			end
			else
			begin
				state_d.rdata = irq_prio_pkg::UNMAPPED_READ;
			end
		end

		// Registered single-bit read of the priority register
		if (sfr_bit_i.rd)
		begin
			if (bit_hits_core)
			begin
				state_d.bit_rdata = core_prio_view[bit_idx];
			end
			else
			begin
				state_d.bit_rdata = 1'b0;
			end
		end

		// The request drops for one cycle after an acknowledge so the
		// stale registered grant is never taken twice
		state_d.irq.valid  = grant & ~(irq_ack_i & state_q.irq.valid);
		state_d.irq.high   = grant_high;
		state_d.irq.src    = grant_src;
		state_d.irq.vector = vector_of(grant_src);
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q           <= '0;
			state_q.core_prio <= irq_prio_pkg::CORE_PRIO_RESET[NUM_CORE_SRC-1:0];
			state_q.ext_en    <= irq_prio_pkg::EXT_EN_RESET[irq_prio_pkg::EXT_FIELD_LSB +:
				irq_prio_pkg::EXT_FIELD_W];
			state_q.ext_prio  <= irq_prio_pkg::EXT_PRIO_RESET[irq_prio_pkg::EXT_FIELD_LSB +:
				irq_prio_pkg::EXT_FIELD_W];
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Register views below are combinations of flops and constant bits only
	assign sfr_rdata_o                   = state_q.rdata;
	assign sfr_bit_rdata_o               = state_q.bit_rdata;
	assign irq_o                         = state_q.irq;
	assign core_interrupt_priority_o     = core_prio_view;
	assign extended_interrupt_enable_o   = ext_en_view;
	assign extended_interrupt_priority_o = ext_prio_view;
	assign soft_src_pending_o            = state_q.soft_pend;
	assign in_service_o                  = busy;

endmodule

// ### tb/irq_prio_ctrl_assertions.sv
// Port-level checks of the interrupt priority block, bound to its top module
`timescale 1ns/10ps
module irq_prio_checker #(
	parameter int unsigned NUM_CORE_SRC = irq_prio_pkg::NUM_CORE_SRC
)
(
	input wire logic                         mclk_i,
	input wire logic                         rst_b_i,
	input wire irq_prio_pkg::sfr_req_t       sfr_i,
	input wire logic                         global_irq_enable_i,
	input wire logic [NUM_CORE_SRC-1:0]      core_irq_enable_i,
	input wire logic [NUM_CORE_SRC-1:0]      core_pending_i,
	input wire logic                         freq_counter_pending_i,
	input wire logic                         soft_flag_wr_i,
	input wire logic [1:0]                   soft_flag_wdata_i,
	input wire logic                         irq_ack_i,
	input wire logic                         irq_reti_i,
	input wire irq_prio_pkg::irq_req_t       irq_o,
	input wire logic [7:0]                   core_interrupt_priority_o,
	input wire logic [7:0]                   extended_interrupt_enable_o,
	input wire logic [7:0]                   extended_interrupt_priority_o,
	input wire logic [1:0]                   soft_src_pending_o,
	input wire irq_prio_pkg::in_service_t    in_service_o
);
	// Arbitration sees last edge's state, so the expectations are kept one cycle late
	logic [9:0] live_q;
	logic [9:0] prio_q;
	logic [4:0] ord;
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			live_q <= '0;
			prio_q <= '0;
		end
		else
		begin
			live_q <= {extended_interrupt_enable_o[4:2], core_irq_enable_i}
				& {soft_src_pending_o, freq_counter_pending_i, core_pending_i}
				& {10{global_irq_enable_i}};
			prio_q <= {extended_interrupt_priority_o[4:2], core_interrupt_priority_o[6:0]};
		end
	end
	assign ord = (irq_o.src < 4'h7) ? {1'b0, irq_o.src} : {1'b0, irq_o.src} + 5'h02;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	sequence ack_taken_s;
		irq_ack_i && irq_o.valid && !irq_reti_i;
	endsequence
	sequence reti_high_s;
		irq_reti_i && !irq_ack_i && in_service_o.hi_active;
	endsequence
	fixed_bits_a: assert property (core_interrupt_priority_o[7] &&
		((extended_interrupt_enable_o | extended_interrupt_priority_o) & 8'he3) == 8'h00)
		else $error("fixed register bits wrong");
	core_write_a: assert property (sfr_i.wr && sfr_i.addr == 8'hb8 |=>
		core_interrupt_priority_o == {1'b1, $past(sfr_i.wdata[6:0])})
		else $error("core priority write not taken");
	ext_enable_a: assert property (sfr_i.wr && sfr_i.addr == 8'he6 |=>
		extended_interrupt_enable_o == {3'h0, $past(sfr_i.wdata[4:2]), 2'h0})
		else $error("extended enable write not taken");
	ext_prio_a: assert property (sfr_i.wr && sfr_i.addr == 8'hf6 |=>
		extended_interrupt_priority_o == {3'h0, $past(sfr_i.wdata[4:2]), 2'h0})
		else $error("extended priority write not taken");
	source_live_a: assert property (irq_o.valid |-> live_q[irq_o.src])
		else $error("request from a masked or idle source");
	level_match_a: assert property (irq_o.valid |-> irq_o.high == prio_q[irq_o.src])
		else $error("request level differs from priority bit");
	fixed_order_a: assert property (irq_o.valid |-> (live_q
		& (irq_o.high ? prio_q : 10'h3ff) & ((10'h001 << irq_o.src) - 10'h001)) == 10'h000)
		else $error("lower source skipped");
	vector_a: assert property (irq_o.valid |->
		irq_o.vector == 16'h0003 + 16'(ord) * 16'h0008)
		else $error("vector wrong");
	global_off_a: assert property (!global_irq_enable_i |=> !irq_o.valid)
		else $error("request while globally disabled");
	nesting_a: assert property (irq_o.valid |-> !$past(in_service_o.hi_active)
		&& (irq_o.high || !$past(in_service_o.lo_active)))
		else $error("request not blocked by handler in progress");
	ack_mark_a: assert property (ack_taken_s |=> !irq_o.valid
		&& ($past(irq_o.high) ? in_service_o.hi_active : in_service_o.lo_active))
		else $error("ack did not mark handler level");
	reti_close_a: assert property (reti_high_s |=> !in_service_o.hi_active
		&& $stable(in_service_o.lo_active))
		else $error("return did not close high handler");
	soft_set_a: assert property ($rose(soft_src_pending_o[0]) |->
		$past(soft_flag_wr_i && soft_flag_wdata_i[0]))
		else $error("soft flag set without write");
endmodule
bind irq_prio_ctrl irq_prio_checker #(.NUM_CORE_SRC(NUM_CORE_SRC)) u_chk (.mclk_i, .rst_b_i,
	.sfr_i, .global_irq_enable_i, .core_irq_enable_i, .core_pending_i,
	.freq_counter_pending_i, .soft_flag_wr_i, .soft_flag_wdata_i, .irq_ack_i, .irq_reti_i,
	.irq_o, .core_interrupt_priority_o, .extended_interrupt_enable_o,
	.extended_interrupt_priority_o, .soft_src_pending_o, .in_service_o);

// ### tb/core_model.sv
// Processor core stand-in: acknowledges requests after a set wait, returns on demand
`timescale 1ns/10ps
module core_model (
	input  wire logic                   mclk_i,
	input  wire logic                   rst_b_i,
	input  wire irq_prio_pkg::irq_req_t irq_i,
	input  wire logic                   ack_en_i,
	input  wire logic [3:0]             ack_wait_i,
	input  wire logic                   reti_req_i,
	output logic                        irq_ack_o,
	output logic                        irq_reti_o
);
	logic [3:0] wait_q;
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wait_q     <= 4'h0;
			irq_ack_o  <= 1'b0;
			irq_reti_o <= 1'b0;
		end
		else
		begin
			irq_reti_o <= reti_req_i;
			irq_ack_o  <= 1'b0;
			// One ack per request; a dropped request restarts the wait
			if (irq_ack_o || !ack_en_i || !irq_i.valid)
				wait_q <= 4'h0;
			else if (wait_q >= ack_wait_i)
				irq_ack_o <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule

// ### tb/tb_irq_prio_ctrl.sv
// Self-checking bench of the interrupt priority block
`timescale 1ns/10ps
`define CHK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("BAD %s expected %h seen %h", what, exp, got); \
		end \
	end
module tb_irq_prio_ctrl;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} row_t;
	int                        miscompares = 0;
	int                        comparisons = 0;
	logic                      mclk_i = 1'b0;
	logic                      rst_b_i = 1'b0;
	irq_prio_pkg::sfr_req_t    sfr = '0;
	irq_prio_pkg::sfr_bit_req_t sfr_bit = '0;
	logic                      global_en = 1'b1;
	logic [6:0]                core_en = 7'h7f;
	logic [6:0]                core_pend = 7'h00;
	logic                      fc_pend = 1'b0;
	logic                      soft_wr = 1'b0;
	logic [1:0]                soft_wd = 2'h0;
	logic                      ack_en = 1'b0;
	logic [3:0]                ack_wait = 4'h0;
	logic                      reti_req = 1'b0;
	logic                      ack;
	logic                      reti;
	logic [7:0]                rdata;
	logic                      bit_rdata;
	irq_prio_pkg::irq_req_t    irq;
	logic [7:0]                cprio;
	logic [7:0]                xen;
	logic [7:0]                xprio;
	logic [1:0]                soft_pend;
	irq_prio_pkg::in_service_t insvc;
	logic [7:0]                q;
	logic                      b;
	logic [9:0]                hi_exp = 10'h2d5;
	row_t                      rows [8] = '{
		'{8'hb8, 8'h45, 8'hc5}, '{8'hb8, 8'h7f, 8'hff}, '{8'hb8, 8'h00, 8'h80},
		'{8'he6, 8'hfc, 8'h1c}, '{8'he6, 8'h14, 8'h14}, '{8'hf6, 8'hfc, 8'h1c},
		'{8'hf6, 8'h08, 8'h08}, '{8'h55, 8'haa, 8'h00}};

	always #4 mclk_i = ~mclk_i;

	irq_prio_ctrl u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sfr_i(sfr), .sfr_bit_i(sfr_bit),
		.global_irq_enable_i(global_en), .core_irq_enable_i(core_en),
		.core_pending_i(core_pend), .freq_counter_pending_i(fc_pend),
		.soft_flag_wr_i(soft_wr), .soft_flag_wdata_i(soft_wd), .irq_ack_i(ack),
		.irq_reti_i(reti), .sfr_rdata_o(rdata), .sfr_bit_rdata_o(bit_rdata), .irq_o(irq),
		.core_interrupt_priority_o(cprio), .extended_interrupt_enable_o(xen),
		.extended_interrupt_priority_o(xprio), .soft_src_pending_o(soft_pend),
		.in_service_o(insvc));

	core_model u_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .irq_i(irq), .ack_en_i(ack_en),
		.ack_wait_i(ack_wait), .reti_req_i(reti_req), .irq_ack_o(ack), .irq_reti_o(reti));

	task automatic print_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic sfr_acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk_i);
		sfr <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge mclk_i);
		sfr.wr <= 1'b0;
		sfr.rd <= 1'b0;
		#1 q = rdata;
	endtask

	task automatic bit_acc(input logic [7:0] a, input logic d, input logic w);
		@(posedge mclk_i);
		sfr_bit <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge mclk_i);
		sfr_bit.wr <= 1'b0;
		sfr_bit.rd <= 1'b0;
		#1 b = bit_rdata;
	endtask

	task automatic set_src(input int s, input logic v);
		@(posedge mclk_i);
		if (s < 7)
			core_pend[s] <= v;
		else if (s == 7)
			fc_pend <= v;
		else
		begin
			// The flags are written as a pair, so the other flag keeps its last value
			soft_wr <= 1'b1;
			soft_wd[s - 8] <= v;
		end
		@(posedge mclk_i);
		soft_wr <= 1'b0;
		#1;
	endtask

	task automatic wait_valid();
		int n;
		n = 0;
		while (irq.valid !== 1'b1 && n < 10)
		begin
			@(posedge mclk_i);
			#1 n++;
		end
		if (irq.valid !== 1'b1)
		begin
			miscompares++;
			print_verdict();
		end
	endtask

	initial
	begin
		repeat (100000) @(posedge mclk_i);
		miscompares++;
		print_verdict();
	end

	initial
	begin
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		#1;
		`CHK("prio reset", irq_prio_pkg::CORE_PRIO_RESET, cprio)
		`CHK("ext reset", 16'h0000, {xen, xprio})
		// Reserved bits 1:0 of the extended registers are always written as zero
		foreach (rows[i])
		begin
			sfr_acc(rows[i].addr, rows[i].wdata, 1'b1);
			sfr_acc(rows[i].addr, 8'h00, 1'b0);
			`CHK("byte read", rows[i].rdata, q)
		end
		for (int n = 0; n < 8; n++)
		begin
			bit_acc(8'hb8 + 8'(n), 1'b1, 1'b1);
			bit_acc(8'hb8 + 8'(n), 1'b0, 1'b0);
			`CHK("bit set", 1'b1, b)
			bit_acc(8'hb8 + 8'(n), 1'b0, 1'b1);
			bit_acc(8'hb8 + 8'(n), 1'b0, 1'b0);
			`CHK("bit clear", n == 7, b)
		end
		sfr_acc(8'hb8, 8'h55, 1'b1);
		sfr_acc(8'he6, 8'h1c, 1'b1);
		sfr_acc(8'hf6, 8'h14, 1'b1);
		for (int s = 0; s < 10; s++)
		begin
			set_src(s, 1'b1);
			wait_valid();
			`CHK("source", 4'(s), irq.src)
			`CHK("level", hi_exp[s], irq.high)
			`CHK("vector", 16'h0003 + 16'(8 * (s < 7 ? s : s + 2)), irq.vector)
			set_src(s, 1'b0);
			settle(2);
		end
		// Masking: extended enables off, then the two soft enables opened one at a time
		sfr_acc(8'he6, 8'h00, 1'b1);
		set_src(7, 1'b1);
		settle(2);
		`CHK("soft untouched", 2'h0, soft_pend)
		`CHK("fc masked", 1'b0, irq.valid)
		set_src(8, 1'b1);
		set_src(9, 1'b1);
		settle(2);
		`CHK("soft masked", 1'b0, irq.valid)
		sfr_acc(8'he6, 8'h10, 1'b1);
		wait_valid();
		`CHK("soft1 open", 4'h9, irq.src)
		sfr_acc(8'he6, 8'h08, 1'b1);
		settle(2);
		`CHK("soft0 open", 4'h8, irq.src)
		@(posedge mclk_i);
		global_en <= 1'b0;
		settle(3);
		`CHK("global off", 1'b0, irq.valid)
		// Nesting: two low sources at once, then a high one preempts
		sfr_acc(8'he6, 8'h00, 1'b1);
		sfr_acc(8'hb8, 8'h08, 1'b1);
		@(posedge mclk_i);
		global_en <= 1'b1;
		ack_wait <= 4'h3;
		core_pend <= 7'h03;
		wait_valid();
		`CHK("tie order", 4'h0, irq.src)
		@(posedge mclk_i);
		ack_en <= 1'b1;
		settle(8);
		`CHK("low blocked", 3'h2, {insvc, irq.valid})
		@(posedge mclk_i);
		ack_en <= 1'b0;
		ack_wait <= 4'h0;
		core_pend[3] <= 1'b1;
		wait_valid();
		`CHK("preempt", 5'h13, {irq.high, irq.src})
		@(posedge mclk_i);
		ack_en <= 1'b1;
		settle(4);
		`CHK("both active", 2'h3, insvc)
		@(posedge mclk_i);
		ack_en <= 1'b0;
		reti_req <= 1'b1;
		@(posedge mclk_i);
		reti_req <= 1'b0;
		settle(3);
		`CHK("high closed", 2'h1, insvc)
		// The pending tick is live again; its own enable must still mask it
		@(posedge mclk_i);
		core_en <= 7'h00;
		settle(3);
		`CHK("core masked", 1'b0, irq.valid)
		// Second reset in mid-run restores the register views
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		settle(2);
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		settle(1);
		`CHK("re-reset", 18'h2_0000, {cprio, xen, insvc})
		print_verdict();
	end
endmodule
